// file: inc/gptu_pkg.sv
`default_nettype none

package gptu_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: one state time unit is half a clock period.
	localparam int TCL_PER_CLK   = 2;
	localparam int G1_RES_TCL    = 16;
	localparam int G2_RES_TCL    = 8;
	localparam int G1_DIV        = G1_RES_TCL / TCL_PER_CLK;
	localparam int G2_DIV        = G2_RES_TCL / TCL_PER_CLK;
	localparam logic [2:0] G1_DIV_LAST = 3'(G1_DIV - 1);
	localparam logic [1:0] G2_DIV_LAST = 2'(G2_DIV - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses on the APB.
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_STRIDE  = 8'h04;
	localparam logic [ADDR_W-1:0] REG_G1_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_G1_VAL  = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_G2_CTRL = 8'h18;
	localparam logic [ADDR_W-1:0] REG_G2_VAL  = 8'h20;
	localparam logic [ADDR_W-1:0] REG_CAPTURE_RELOAD_REGISTER  = 8'h28;
	localparam logic [ADDR_W-1:0] REG_FLAGS   = 8'h2C;

	////////////////////////////////////////////////////////////////////////////////
	// Timer indices, pin vector layout and flag bits.
	localparam int NG1     = 3;
	localparam int NG2     = 2;
	localparam int CORE    = 0;
	localparam int G2_MAIN = 0;
	localparam int G2_AUX  = 1;
	localparam int P_G1_IN  = 0;
	localparam int P_G1_DIR = 3;
	localparam int P_G2_IN  = 6;
	localparam int P_G2_DIR = 8;
	localparam int P_CAPTURE_INPUT_PIN  = 10;
	localparam int NPIN     = 11;
	localparam int FL_G1   = 0;
	localparam int FL_G2   = 3;
	localparam int FL_CAP  = 5;
	localparam int FLAG_W  = 6;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_MIN = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// Modes and control layouts.
	typedef enum logic [1:0] {GPTU_TIMER, GPTU_GATED, GPTU_COUNTER, GPTU_QUAD} gptu_mode_t;
	typedef enum logic [1:0] {GPTU_NORMAL, GPTU_CAPTURE, GPTU_RELOAD, GPTU_FN_RSV} gptu_func_t;
	typedef enum logic [1:0] {GPTU_RL_EXT, GPTU_RL_RISE, GPTU_RL_FALL, GPTU_RL_BOTH} gptu_rtrig_t;

	typedef struct packed {
		logic        cnt_tl;
		gptu_rtrig_t rtrig;
		gptu_func_t  func;
		logic [1:0]  edge_sel;
		logic        gate_low;
		logic        out_en;
		logic [2:0]  pre;
		logic        run;
		logic        ext_dir;
		logic        down;
		gptu_mode_t  mode;
	} gptu_g1_ctrl_t;

	typedef struct packed {
		logic       clr_cap;
		logic [1:0] cap_edge;
		logic [1:0] cap_src;
		logic       opt;
		logic [1:0] edge_sel;
		logic       out_en;
		logic [2:0] pre;
		logic       run;
		logic       ext_dir;
		logic       down;
		logic       ext_clk;
	} gptu_g2_ctrl_t;

	localparam int G1_CTRL_W = $bits(gptu_g1_ctrl_t);
	localparam int G2_CTRL_W = $bits(gptu_g2_ctrl_t);

	////////////////////////////////////////////////////////////////////////////////
	// Selected edge between two samples: bit 0 rising, bit 1 falling.
	function automatic logic gptu_edge(input logic prev, input logic cur, input logic [1:0] sel);
		gptu_edge = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
	endfunction

	// Prescaler hit: divides the base tick by two to the power of sel.
	function automatic logic gptu_pre_hit(input logic [7:0] cnt, input logic [2:0] sel);
		logic [7:0] mask;
		mask = ~(8'hFF << sel);
		gptu_pre_hit = ((cnt & mask) == mask);
	endfunction

	// One count step; the top bit flags the wrap.
	function automatic logic [16:0] gptu_step(input logic [15:0] v, input logic up);
		if (up) begin
			gptu_step = {(v == CNT_MAX), 16'(v + 16'h0001)};
		end else begin
			gptu_step = {(v == CNT_MIN), 16'(v - 16'h0001)};
		end
	endfunction

endpackage

`default_nettype wire

// file: rtl/gptu_top.sv
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module gptu_top (
	// Clock and reset.
	input  wire logic                       mclk,
	input  wire logic                       resetn,
	// APB slave.
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [gptu_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	// First module pins.
	input  wire logic                       core_gate_clock_input,
	input  wire logic                       core_direction_input,
	input  wire logic                       aux_low_gate_clock_input,
	input  wire logic                       aux_low_direction_input,
	input  wire logic                       aux_high_gate_clock_input,
	input  wire logic                       aux_high_direction_input,
	// Second module pins.
	input  wire logic                       second_main_gate_clock_input,
	input  wire logic                       second_main_direction_input,
	input  wire logic                       second_aux_gate_clock_input,
	input  wire logic                       second_aux_direction_input,
	input  wire logic                       capture_input_pin,
	// Outputs.
	output logic                            core_toggle_output,
	output logic                            second_toggle_output,
	output logic                            capcom_clock_pulse
);
	import gptu_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Whole state of the block.
	typedef struct packed {
		logic [NPIN-1:0]                sy1;
		logic [NPIN-1:0]                sy2;
		logic [NPIN-1:0]                sm1;
		logic [NPIN-1:0]                sm2;
		logic [2:0]                     dv1;
		logic [1:0]                     dv2;
		logic [7:0]                     ps1;
		logic [7:0]                     ps2;
		gptu_g1_ctrl_t [NG1-1:0]        c1;
		logic [NG1-1:0][15:0]           v1;
		gptu_g2_ctrl_t [NG2-1:0]        c2;
		logic [NG2-1:0][15:0]           v2;
		logic [15:0]                    cr;
		logic [FLAG_W-1:0]              fl;
		logic                           tl1;
		logic                           tl1_p;
		logic                           tl2;
		logic                           tl2_p;
		logic                           o1;
		logic                           o2;
		logic                           ovf;
		logic [31:0]                    rd;
		logic                           rdy;
		logic                           err;
	} gptu_state_t;

	logic [1:0]        rst_q;
	logic              rst_sync_n;
	gptu_state_t       s_r;
	gptu_state_t       s_nxt;
	logic [NPIN-1:0]   pins;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'h1};
		end
	end
	assign rst_sync_n = rst_q[1];

	// Pin vector in a fixed layout.
	assign pins = {capture_input_pin,
		second_aux_direction_input, second_main_direction_input,
		second_aux_gate_clock_input, second_main_gate_clock_input,
		aux_high_direction_input, aux_low_direction_input, core_direction_input,
		aux_high_gate_clock_input, aux_low_gate_clock_input, core_gate_clock_input};

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic for the whole block.
	always_comb begin
		logic              t1;
		logic              t2;
		logic              acc;
		logic              setup;
		logic              inc;
		logic              up;
		logic              trig;
		logic              hit;
		logic              a_new;
		logic              a_old;
		logic              b_new;
		logic              b_old;
		logic [16:0]       st;
		logic [FLAG_W-1:0] fset;
		logic [FLAG_W-1:0] fclr;
		logic [31:0]       rdv;
		logic              bad;
		gptu_g1_ctrl_t     c;
		gptu_g2_ctrl_t     d;
		t1    = 1'h0;
		t2    = 1'h0;
		acc   = 1'h0;
		setup = 1'h0;
		inc   = 1'h0;
		up    = 1'h0;
		trig  = 1'h0;
		hit   = 1'h0;
		a_new = 1'h0;
		a_old = 1'h0;
		b_new = 1'h0;
		b_old = 1'h0;
		st    = '0;
		fset  = '0;
		fclr  = '0;
		rdv   = '0;
		bad   = 1'h1;
		c     = '0;
		d     = '0;
		s_nxt = s_r;

		// Two-stage pin synchroniser; only the second stage is read.
		s_nxt.sy1 = pins;
		s_nxt.sy2 = s_r.sy1;

		// Base ticks: 8 clocks for the first module, 4 for the second.
		t1 = (s_r.dv1 == G1_DIV_LAST);
		t2 = (s_r.dv2 == G2_DIV_LAST);
		s_nxt.dv1 = t1 ? 3'h0 : 3'(s_r.dv1 + 3'h1);
		s_nxt.dv2 = t2 ? 2'h0 : 2'(s_r.dv2 + 2'h1);
		if (t1) begin
			s_nxt.ps1 = 8'(s_r.ps1 + 8'h01);
			s_nxt.sm1 = s_r.sy2;
		end
		if (t2) begin
			s_nxt.ps2 = 8'(s_r.ps2 + 8'h01);
			s_nxt.sm2 = s_r.sy2;
		end
		s_nxt.tl1_p = s_r.tl1;
		s_nxt.tl2_p = s_r.tl2;
		s_nxt.ovf   = 1'h0;

		////////////////////////////////////////////////////////////////////////
		// First module: core first, then the two auxiliary timers.
		for (int i = 0; i < NG1; i++) begin
			c     = s_r.c1[i];
			a_new = s_r.sy2[P_G1_IN + i];
			a_old = s_r.sm1[P_G1_IN + i];
			b_new = s_r.sy2[P_G1_DIR + i];
			b_old = s_r.sm1[P_G1_DIR + i];
			up    = ~(c.down ^ (c.ext_dir & b_new));
			case (c.mode)
				GPTU_TIMER: begin
					inc = t1 & gptu_pre_hit(s_r.ps1, c.pre);
				end
				GPTU_GATED: begin
					inc = t1 & gptu_pre_hit(s_r.ps1, c.pre) & (a_new ^ c.gate_low);
				end
				GPTU_COUNTER: begin
					if (i != CORE && c.cnt_tl) begin
						inc = gptu_edge(s_r.tl1_p, s_r.tl1, c.edge_sel);
					end else begin
						inc = t1 & gptu_edge(a_old, a_new, c.edge_sel);
					end
				end
				GPTU_QUAD: begin
					inc = t1 & ((a_new ^ a_old) | (b_new ^ b_old));
					up  = a_new ^ b_old ^ c.down;
				end
				default: begin
					inc = 1'h0;
				end
			endcase
			// A timer in capture or reload function does not count.
			if (c.run && inc && c.func == GPTU_NORMAL) begin
				st = gptu_step(s_r.v1[i], up);
				s_nxt.v1[i] = st[15:0];
				if (st[16]) begin
					fset[FL_G1 + i] = 1'h1;
					if (i == CORE) begin
						s_nxt.tl1 = ~s_r.tl1;
					end
				end
			end
			trig = t1 & gptu_edge(a_old, a_new, c.edge_sel);
			if (i != CORE && c.func == GPTU_CAPTURE && trig) begin
				s_nxt.v1[i] = s_r.v1[CORE];
			end
			if (i != CORE && c.func == GPTU_RELOAD) begin
				case (c.rtrig)
					GPTU_RL_EXT: begin
						hit = trig;
					end
					GPTU_RL_RISE: begin
						hit = s_r.tl1 & ~s_r.tl1_p;
					end
					GPTU_RL_FALL: begin
						hit = ~s_r.tl1 & s_r.tl1_p;
					end
					default: begin
						hit = s_r.tl1 ^ s_r.tl1_p;
					end
				endcase
				if (hit) begin
					s_nxt.v1[CORE] = s_r.v1[i];
				end
			end
		end
		s_nxt.o1 = s_r.c1[CORE].out_en & s_nxt.tl1;

		////////////////////////////////////////////////////////////////////////
		// Second module: main timer, then auxiliary timer.
		for (int j = 0; j < NG2; j++) begin
			d     = s_r.c2[j];
			a_new = s_r.sy2[P_G2_IN + j];
			a_old = s_r.sm2[P_G2_IN + j];
			b_new = s_r.sy2[P_G2_DIR + j];
			up    = ~(d.down ^ (d.ext_dir & b_new));
			if (j == G2_AUX && d.opt) begin
				inc = gptu_edge(s_r.tl2_p, s_r.tl2, d.edge_sel);
			end else if (d.ext_clk) begin
				inc = t2 & gptu_edge(a_old, a_new, d.edge_sel);
			end else begin
				inc = t2 & gptu_pre_hit(s_r.ps2, d.pre);
			end
			if (d.run && inc) begin
				st = gptu_step(s_r.v2[j], up);
				s_nxt.v2[j] = st[15:0];
				if (st[16]) begin
					fset[FL_G2 + j] = 1'h1;
					if (j == G2_MAIN) begin
						s_nxt.tl2 = ~s_r.tl2;
						s_nxt.ovf = 1'h1;
						if (d.opt) begin
							s_nxt.v2[G2_MAIN] = s_r.cr;
						end
					end
				end
			end
		end
		s_nxt.o2 = s_r.c2[G2_MAIN].out_en & s_nxt.tl2;

		// Capture of the auxiliary timer into the capture/reload register.
		d = s_r.c2[G2_AUX];
		if (d.cap_src == 2'h0) begin
			hit = gptu_edge(s_r.sm2[P_CAPTURE_INPUT_PIN], s_r.sy2[P_CAPTURE_INPUT_PIN], d.cap_edge);
		end else begin
			hit = (d.cap_src[0] & gptu_edge(s_r.sm2[P_G1_IN + CORE], s_r.sy2[P_G1_IN + CORE], d.cap_edge))
				| (d.cap_src[1] & gptu_edge(s_r.sm2[P_G1_DIR + CORE], s_r.sy2[P_G1_DIR + CORE], d.cap_edge));
		end
		if (t2 && hit) begin
			s_nxt.cr = s_r.v2[G2_AUX];
			fset[FL_CAP] = 1'h1;
			if (d.clr_cap) begin
				s_nxt.v2[G2_AUX] = CNT_MIN;
			end
		end

		////////////////////////////////////////////////////////////////////////
		// APB: answer prepared in the setup cycle, one access cycle.
		setup = psel & ~penable;
		acc   = psel & penable & s_r.rdy;
		for (int i = 0; i < NG1; i++) begin
			if (paddr == 8'(REG_G1_CTRL + REG_STRIDE * 8'(i))) begin
				rdv = 32'(s_r.c1[i]);
				bad = 1'h0;
				if (acc && pwrite) begin
					s_nxt.c1[i] = gptu_g1_ctrl_t'(pwdata[G1_CTRL_W-1:0]);
				end
			end
			if (paddr == 8'(REG_G1_VAL + REG_STRIDE * 8'(i))) begin
				rdv = 32'(s_r.v1[i]);
				bad = 1'h0;
				if (acc && pwrite) begin
					s_nxt.v1[i] = pwdata[15:0];
				end
			end
		end
		for (int j = 0; j < NG2; j++) begin
			if (paddr == 8'(REG_G2_CTRL + REG_STRIDE * 8'(j))) begin
				rdv = 32'(s_r.c2[j]);
				bad = 1'h0;
				if (acc && pwrite) begin
					s_nxt.c2[j] = gptu_g2_ctrl_t'(pwdata[G2_CTRL_W-1:0]);
				end
			end
			if (paddr == 8'(REG_G2_VAL + REG_STRIDE * 8'(j))) begin
				rdv = 32'(s_r.v2[j]);
				bad = 1'h0;
				if (acc && pwrite) begin
					s_nxt.v2[j] = pwdata[15:0];
				end
			end
		end
		if (paddr == REG_CAPTURE_RELOAD_REGISTER) begin
			rdv = 32'(s_r.cr);
			bad = 1'h0;
			if (acc && pwrite) begin
				s_nxt.cr = pwdata[15:0];
			end
		end
		if (paddr == REG_FLAGS) begin
			rdv = 32'(s_r.fl);
			bad = 1'h0;
			if (acc && pwrite) begin
				fclr = pwdata[FLAG_W-1:0];
			end
		end
		// Write-one-to-clear; a new event in the same cycle wins.
		s_nxt.fl = (s_r.fl & ~fclr) | fset;
		s_nxt.rdy = setup;
		s_nxt.err = setup & bad;
		if (setup) begin
			s_nxt.rd = rdv;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register.
	assign prdata               = s_r.rd;
	assign pready               = s_r.rdy;
	assign pslverr              = s_r.err;
	assign core_toggle_output   = s_r.o1;
	assign second_toggle_output = s_r.o2;
	assign capcom_clock_pulse   = s_r.ovf;

endmodule

`default_nettype wire

// file: tb/gptu_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module gptu_monitor (
	// Clock and reset.
	input wire logic        mclk,
	input wire logic        resetn,
	// Register bus.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Timer outputs.
	input wire logic        core_toggle_output,
	input wire logic        second_toggle_output,
	input wire logic        capcom_clock_pulse
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	////////////////////////////////////////////////////////////////////////////////
	// Bus answers come one cycle after setup and last one cycle.
	AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
		else $error("ready missing after setup");
	AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
		else $error("ready outside an access");
	AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_REFUSED_READS_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	AST_READ_DATA_HOLDS: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data changed without setup");

	////////////////////////////////////////////////////////////////////////////////
	// Outputs stay quiet after reset and never move faster than the base tick.
	AST_QUIET_AFTER_RESET: assert property ($rose(resetn) |-> !pready && !capcom_clock_pulse ##1 !pready)
		else $error("output active right after reset");
	AST_CAPCOM_PULSE_SPACING: assert property (capcom_clock_pulse |=> !capcom_clock_pulse [*3])
		else $error("compare clock pulses too close");
	AST_CORE_TOGGLE_SPACING: assert property ($changed(core_toggle_output) |=> $stable(core_toggle_output) [*7])
		else $error("core toggle output moved too fast");
	AST_SECOND_TOGGLE_SPACING: assert property ($changed(second_toggle_output) |=> $stable(second_toggle_output) [*3])
		else $error("second toggle output moved too fast");

	// Main scenarios reached.
	COV_CAPCOM: cover property (capcom_clock_pulse);
	COV_CORE_TOGGLE: cover property ($rose(core_toggle_output));
	COV_REFUSED: cover property (pready && pslverr);
endmodule

`default_nettype wire

// file: tb/gptu_pins_model.sv
`timescale 1ns/1ps
`default_nettype none

module gptu_pins_model (
	// Clock.
	input  wire logic                   mclk,
	// Pin levels towards the block.
	output var  logic [gptu_pkg::NPIN-1:0] pins
);
	import gptu_pkg::*;

	// All pins idle low until a scenario moves them.
	initial begin
		pins = '0;
	end

	// Sets one pin and holds it well beyond a sample tick so no edge is missed.
	task automatic step(input int idx, input logic v);
		@(posedge mclk);
		pins[idx] <= v;
		repeat (19) @(posedge mclk);
	endtask

	// External events: full pulses on one pin.
	task automatic pulse(input int idx, input int n);
		repeat (n) begin
			step(idx, 1'b1);
			step(idx, 1'b0);
		end
	endtask

	// Encoder moving forward: signal A leads signal B by a quarter period.
	task automatic quad(input int n);
		repeat (n) begin
			step(P_G1_IN, 1'b1);
			step(P_G1_DIR, 1'b1);
			step(P_G1_IN, 1'b0);
			step(P_G1_DIR, 1'b0);
		end
	endtask
endmodule

`default_nettype wire

// file: tb/general_purpose_timer_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module general_purpose_timer_unit_tb_top;
	import gptu_pkg::*;

	logic              mclk;
	logic              resetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic [31:0]       rd;
	logic              pready;
	logic              pslverr;
	logic              err;
	logic              core_out;
	logic              sec_out;
	logic              capcom;
	logic [NPIN-1:0]   pins;
	int                n_mismatch;
	int                num_checks;
	int                cyc;
	int                n_capcom;

	gptu_top gptu_top_inst (
		.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_gate_clock_input(pins[P_G1_IN]), .core_direction_input(pins[P_G1_DIR]),
		.aux_low_gate_clock_input(pins[P_G1_IN+1]), .aux_low_direction_input(pins[P_G1_DIR+1]),
		.aux_high_gate_clock_input(pins[P_G1_IN+2]), .aux_high_direction_input(pins[P_G1_DIR+2]),
		.second_main_gate_clock_input(pins[P_G2_IN]), .second_main_direction_input(pins[P_G2_DIR]),
		.second_aux_gate_clock_input(pins[P_G2_IN+1]), .second_aux_direction_input(pins[P_G2_DIR+1]),
		.capture_input_pin(pins[P_CAPTURE_INPUT_PIN]), .core_toggle_output(core_out),
		.second_toggle_output(sec_out), .capcom_clock_pulse(capcom)
	);

	gptu_pins_model gptu_pins_model_inst (
		.mclk(mclk),
		.pins(pins)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clock, cycle limit and compare clock pulse count.
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cyc++;
		if (capcom === 1'b1) begin
			n_capcom++;
		end
		if (cyc == 6000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and comparison helpers.
	task automatic report_and_stop();
		$display("mismatches %0d checks %0d", n_mismatch, num_checks);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One bus transfer; the request holds until ready is sampled high.
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int t;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		t = 0;
		// Ready is looked at mid-cycle, where it has settled, never in the step of its own edge.
		do begin
			@(negedge mclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		rd = prdata;
		err = pslverr;
		if (t >= 20) begin
			n_mismatch++;
		end
		// The rising edge that samples ready high completes the transfer; release follows it.
		@(posedge mclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rd, exp);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		repeat (5) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		// Reset state and a refused address.
		chk(REG_FLAGS, 32'h0);
		apb(1'b0, 8'h30, 32'h0);
		cmp({31'h0, err}, 32'h1);
		cmp(rd, 32'h0);
		// Core wraps upward and flips its toggle latch.
		wr(REG_G1_VAL, 32'hFFFF);
		wr(REG_G1_CTRL, 32'h110);
		repeat (20) @(posedge mclk);
		cmp({31'h0, core_out}, 32'h1);
		chk(REG_FLAGS, 32'h1);
		wr(REG_FLAGS, 32'h3F);
		chk(REG_FLAGS, 32'h0);
		// Low auxiliary wraps downward.
		wr(REG_G1_VAL + 8'h04, 32'h0);
		wr(REG_G1_CTRL + 8'h04, 32'h14);
		repeat (20) @(posedge mclk);
		chk(REG_FLAGS, 32'h2);
		// High auxiliary counts five rising edges.
		wr(REG_G1_CTRL + 8'h08, 32'h412);
		gptu_pins_model_inst.pulse(P_G1_IN + 2, 5);
		chk(REG_G1_VAL + 8'h08, 32'h5);
		// Gated core holds while the gate is low, then counts.
		wr(REG_G1_CTRL, 32'h11);
		wr(REG_G1_VAL, 32'h0);
		repeat (40) @(posedge mclk);
		chk(REG_G1_VAL, 32'h0);
		gptu_pins_model_inst.pulse(P_G1_IN, 1);
		apb(1'b0, REG_G1_VAL, 32'h0);
		cmp({31'h0, (rd == 32'h2 || rd == 32'h3)}, 32'h1);
		// Encoder tracking, four counts per period.
		wr(REG_G1_VAL, 32'h0);
		wr(REG_G1_CTRL, 32'hC13);
		gptu_pins_model_inst.quad(3);
		chk(REG_G1_VAL, 32'hC);
		// Capture of the stopped core, then reload into it.
		wr(REG_G1_CTRL, 32'h0);
		wr(REG_G1_VAL, 32'h1234);
		wr(REG_G1_CTRL + 8'h04, 32'h1410);
		gptu_pins_model_inst.pulse(P_G1_IN + 1, 1);
		chk(REG_G1_VAL + 8'h04, 32'h1234);
		wr(REG_G1_VAL + 8'h08, 32'h0777);
		wr(REG_G1_CTRL + 8'h08, 32'h2410);
		gptu_pins_model_inst.pulse(P_G1_IN + 2, 1);
		chk(REG_G1_VAL, 32'h0777);
		// Second module capture with clear, from the capture pin and the core gate pin.
		wr(REG_G2_VAL + 8'h04, 32'hABC);
		wr(REG_G2_CTRL, 32'hA000);
		wr(REG_G2_CTRL + 8'h04, 32'hA000);
		gptu_pins_model_inst.pulse(P_CAPTURE_INPUT_PIN, 1);
		chk(REG_CAPTURE_RELOAD_REGISTER, 32'hABC);
		chk(REG_G2_VAL + 8'h04, 32'h0);
		apb(1'b0, REG_FLAGS, 32'h0);
		cmp(rd & 32'h20, 32'h20);
		wr(REG_G2_VAL + 8'h04, 32'hDEF);
		wr(REG_G2_CTRL, 32'hA800);
		wr(REG_G2_CTRL + 8'h04, 32'hA800);
		gptu_pins_model_inst.pulse(P_G1_IN, 1);
		chk(REG_CAPTURE_RELOAD_REGISTER, 32'hDEF);
		// Second main wrap: toggle output and one compare clock pulse.
		wr(REG_G2_VAL, 32'hFFFF);
		n_capcom = 0;
		wr(REG_G2_CTRL, 32'h88);
		repeat (20) @(posedge mclk);
		cmp({31'h0, sec_out}, 32'h1);
		cmp(32'(n_capcom), 32'h1);
		report_and_stop();
	end
endmodule

bind gptu_top gptu_monitor gptu_monitor_inst (
	.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .core_toggle_output(core_toggle_output),
	.second_toggle_output(second_toggle_output), .capcom_clock_pulse(capcom_clock_pulse)
);

`default_nettype wire
